// ===== verilog/fdg_pkg.sv
// package for the floppy interface glue: constants, lookup table and carriers.
// assumes a single 40 MHz system clock standing in for the 16 MHz oscillator domain.
package fdg_pkg;

  localparam int unsigned fdg_drives = 4;
  localparam int unsigned fdg_unit_w = 2;
  localparam logic [3:0] fdg_cnt_zero = 4'h0;
  localparam logic [3:0] fdg_cnt_one = 4'h1;
  localparam logic [3:0] fdg_cnt_max = 4'hF;
  localparam logic [1:0] fdg_div_by2 = 2'h1; // terminal count for /2
  localparam logic [1:0] fdg_div_by4 = 2'h3; // terminal count for /4
  localparam logic [4:0] fdg_fm_div = 5'h1F;  // single density reference divide
  localparam logic [4:0] fdg_mfm_div = 5'h0F; // double density reference divide
  localparam logic [1:0] fdg_precomp_early = 2'h0;
  localparam logic [1:0] fdg_precomp_nominal = 2'h1;
  localparam logic [1:0] fdg_precomp_late = 2'h2;

  // next-count table for all sixteen counts of the correction lookup
  localparam logic [63:0] fdg_corr_table = {
    4'h1, 4'h0, 4'hF, 4'hF, 4'hE, 4'hD, 4'hC, 4'hB,
    4'h6, 4'h5, 4'h4, 4'h3, 4'h3, 4'h2, 4'h1, 4'h1
  };

  // command lines from the controller toward the drives
  typedef struct packed {
    logic step;
    logic direction;
    logic write_gate;
    logic side_select;
    logic fault_reset;
  } fdg_cmd_s;

  // write pulse with its precompensation request
  typedef struct packed {
    logic data;
    logic early;
    logic late;
  } fdg_wr_s;

endpackage

// ===== verilog/fdg_glue.sv
// floppy interface glue: clocks, counter events, decoding, precompensation, data separator.
// assumes all inputs synchronous to clk; the drive cable level shift is done outside.
//
// Functional notes
// RULE1 - controller clock is oscillator divided by 2 or 4, chosen by switches
// RULE2 - selected unit picks its own 8 or 4 MHz controller clock
// RULE3 - channel 0 counter interrupts once per transferred byte
// RULE4 - cascaded channels 1 and 2 interrupt at sector end and drive terminal count
// RULE5 - controller runs without DMA, processor moves each byte on interrupt
// RULE6 - drive ready lines multiplexed into one controller ready input
// RULE7 - decoder gives one select and one head-load line per drive
// RULE8 - head-load lines double as motor-on controls
// RULE9 - write data is precompensated early or late
// RULE10 - write and reference clocks follow single or double density
// RULE11 - correction disabled makes the separator a plain modulo-16 divider
// RULE12 - rising read pulse captures the current counter value; here only a rise in a reference tick cycle is used
// RULE13 - captured zero means in step, counter advances normally
// RULE14 - nonzero capture jumps one or two steps toward sync
// RULE15 - lookup table gives the next count, upper half is plus one; here the table also covers the upper half
// RULE16 - read window is counter divided by 2, total divide by 32
// RULE17 - controller drive commands multiplexed to the drives
// RULE18 - reset clears separator and window, deasserts select and head-load
`timescale 1ns/100ps
`default_nettype none

module fdg_glue
  import fdg_pkg::*;
#(
  parameter int unsigned drives = fdg_drives,
  parameter int unsigned sector_w = 16
)
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // configuration switches, one per drive: high selects divide by 4
  input wire logic [drives-1:0] clock_divide_switches,
  input wire logic mfm_select,
  input wire logic correction_disable,
  // controller selection and strobes
  input wire logic unit_select_bit0,
  input wire logic unit_select_bit1,
  input wire logic head_load_req,
  input wire logic byte_request,
  input wire fdg_cmd_s ctrl_cmd,
  input wire fdg_wr_s ctrl_write,
  // counter programming
  input wire logic sector_load,
  input wire logic [sector_w-1:0] sector_bytes,
  input wire logic irq_ack,
  // drive side
  input wire logic [drives-1:0] drive_ready,
  input wire logic drive_read_pulses,
  // outputs
  output logic ctrl_clock,
  output logic ctrl_ready,
  output logic byte_irq,
  output logic sector_irq,
  output logic sector_end_count,
  output logic [drives-1:0] drive_select_lines,
  output logic [drives-1:0] head_load_lines,
  output fdg_cmd_s drive_cmd,
  output logic write_data_out,
  output logic write_clock,
  output logic density_reference_clock,
  output logic read_data_window,
  output logic [3:0] sep_count
);

  // one-hot decode of the controller's unit selection, used by both decoders
  function automatic logic [drives-1:0] unit_onehot(input logic [1:0] unit);
    logic [drives-1:0] v;
    v = '0;
    v[unit] = 1'b1;
    return v;
  endfunction

  // lookup: all 16 counts from the table when correcting, otherwise plus one modulo 16
  function automatic logic [3:0] next_count(input logic corr, input logic [3:0] cur);
    logic [3:0] r;
    r = cur + fdg_cnt_one;
    if (corr)
      r = fdg_corr_table[cur*4 +: 4];
    return r;
  endfunction

  logic [1:0] unit;
  logic [1:0] div_reg;
  logic [1:0] div_end;
  logic byte_req_reg;
  logic [sector_w-1:0] sector_cnt_reg;
  logic [4:0] ref_cnt_reg;
  logic [4:0] ref_end;
  logic [1:0] pc_phase_reg;
  logic pc_pending_reg;
  logic read_prev_reg;
  logic read_rise;
  logic [3:0] count_next;

  assign unit = {unit_select_bit1, unit_select_bit0};

  // RULE2 per-unit clock choice
  assign div_end = clock_divide_switches[unit] ? fdg_div_by4 : fdg_div_by2;

  // RULE1 divide the oscillator; a unit change only alters the terminal count
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      div_reg <= 2'h0;
      ctrl_clock <= 1'b0;
    end
    else if (clk_en)
    begin
      if (div_reg >= div_end)
        div_reg <= 2'h0;
      else
        div_reg <= div_reg + 2'h1;
      // high for half of each divide period (count 0 of /2, counts 1 and 2 of /4), so /2 and /4 are both square
      ctrl_clock <= (div_reg >= (div_end >> 1)) && (div_reg != div_end);
    end
  end

  // RULE3 per-byte interrupt, rising edge of the byte request, held until ack
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      byte_req_reg <= 1'b0;
      byte_irq <= 1'b0;
    end
    else if (clk_en)
    begin
      byte_req_reg <= byte_request;
      // RULE5 processor services each byte
      if (byte_request && !byte_req_reg)
        byte_irq <= 1'b1; // set wins over a same-cycle ack
      else if (irq_ack)
        byte_irq <= 1'b0;
    end
  end

  // RULE4 cascaded byte count ends the sector with interrupt and terminal count
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sector_cnt_reg <= '0;
      sector_irq <= 1'b0;
      sector_end_count <= 1'b0;
    end
    else if (clk_en)
    begin
      sector_end_count <= 1'b0; // terminal count is a one-cycle pulse
      if (sector_load)
        sector_cnt_reg <= sector_bytes;
      else if (byte_request && !byte_req_reg && sector_cnt_reg != '0)
      begin
        sector_cnt_reg <= sector_cnt_reg - sector_w'(1);
        if (sector_cnt_reg == sector_w'(1))
          sector_end_count <= 1'b1;
      end
      if (byte_request && !byte_req_reg && sector_cnt_reg == sector_w'(1))
        sector_irq <= 1'b1;
      else if (irq_ack)
        sector_irq <= 1'b0;
    end
  end

  // RULE6 ready of the selected drive, RULE7 select/head-load decode,
  // RULE8 head-load also serves as motor-on, RULE17 command pass-through
  always_ff @(posedge clk)
  begin
    // RULE18 reset deasserts drive lines
    if (sys_rst)
    begin
      ctrl_ready <= 1'b0;
      drive_select_lines <= '0;
      head_load_lines <= '0;
      drive_cmd <= '0;
    end
    else if (clk_en)
    begin
      ctrl_ready <= drive_ready[unit];
      drive_select_lines <= unit_onehot(unit);
      head_load_lines <= head_load_req ? unit_onehot(unit) : '0;
      drive_cmd <= ctrl_cmd;
    end
  end

  // RULE10 reference clock divide depends on density, write clock at half rate
  assign ref_end = mfm_select ? fdg_mfm_div : fdg_fm_div;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ref_cnt_reg <= 5'h00;
      density_reference_clock <= 1'b0;
      write_clock <= 1'b0;
    end
    else if (clk_en)
    begin
      if (ref_cnt_reg >= ref_end)
      begin
        ref_cnt_reg <= 5'h00;
        density_reference_clock <= ~density_reference_clock;
        if (density_reference_clock)
          write_clock <= ~write_clock;
      end
      else
        ref_cnt_reg <= ref_cnt_reg + 5'h01;
    end
  end

  // RULE9 early bits go out at once, nominal after one, late after two cycles
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pc_phase_reg <= fdg_precomp_early;
      pc_pending_reg <= 1'b0;
      write_data_out <= 1'b0;
    end
    else if (clk_en)
    begin
      write_data_out <= 1'b0;
      if (ctrl_write.data)
      begin
        if (ctrl_write.early)
          write_data_out <= 1'b1;
        else
        begin
          pc_pending_reg <= 1'b1;
          pc_phase_reg <= ctrl_write.late ? fdg_precomp_late : fdg_precomp_nominal;
        end
      end
      else if (pc_pending_reg)
      begin
        if (pc_phase_reg == fdg_precomp_nominal)
        begin
          write_data_out <= 1'b1;
          pc_pending_reg <= 1'b0;
        end
        else
          pc_phase_reg <= pc_phase_reg - 2'h1;
      end
    end
  end

  // RULE12 capture on the rising edge of the read pulses
  assign read_rise = drive_read_pulses && !read_prev_reg;

  // RULE11 plain count when disabled; RULE13 zero capture keeps counting;
  // RULE14 nonzero capture jumps toward sync; RULE15 table addressing
  always_comb
  begin
    count_next = next_count(read_rise && !correction_disable, sep_count);
  end

  // separator counter steps on each reference clock tick
  always_ff @(posedge clk)
  begin
    // RULE18 reset clears separator and window
    if (sys_rst)
    begin
      read_prev_reg <= 1'b0;
      sep_count <= fdg_cnt_zero;
      read_data_window <= 1'b0;
    end
    else if (clk_en)
    begin
      read_prev_reg <= drive_read_pulses;
      if (ref_cnt_reg >= ref_end)
      begin
        sep_count <= count_next;
        // RULE16 window toggles when the counter steps from 15 to 0
        if (sep_count == fdg_cnt_max && count_next == fdg_cnt_zero)
          read_data_window <= ~read_data_window;
      end
    end
  end

endmodule

`default_nettype wire

// ===== testbench/fdg_glue_sva.sv
// checker: port-level timing of the floppy glue.
// assumes binding to fdg_glue with clk_en held high.
`timescale 1ns/100ps
`default_nettype none
module fdg_glue_sva
  import fdg_pkg::*;
#(
  parameter int unsigned drives = fdg_drives
)
(
  // watched ports
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic unit_select_bit0,
  input wire logic unit_select_bit1,
  input wire logic head_load_req,
  input wire logic byte_request,
  input wire logic irq_ack,
  input wire logic [drives-1:0] drive_ready,
  input wire fdg_wr_s ctrl_write,
  input wire logic ctrl_ready,
  input wire logic byte_irq,
  input wire logic sector_irq,
  input wire logic sector_end_count,
  input wire logic [drives-1:0] drive_select_lines,
  input wire logic [drives-1:0] head_load_lines,
  input wire logic [3:0] sep_count,
  input wire logic write_data_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // selected unit as one-hot
  wire logic [1:0] unit = {unit_select_bit1, unit_select_bit0};
  wire logic [drives-1:0] unit_hot = drives'(1) << unit;
  // end of sector: one-cycle pulse, irq left standing
  sequence s_tc_done;
    ##1 (!sector_end_count && sector_irq);
  endsequence
  a_reset_clear: assert property (disable iff (1'b0) sys_rst |=>
    drive_select_lines == '0 && head_load_lines == '0 && sep_count == 4'h0) else $error("reset");
  a_select_decode: assert property (1'b1 |=> drive_select_lines == $past(unit_hot))
    else $error("select");
  a_head_load: assert property (1'b1 |=>
    head_load_lines == ($past(head_load_req) ? $past(unit_hot) : '0)) else $error("head");
  a_ready_mux: assert property (1'b1 |=> ctrl_ready == $past(drive_ready[unit]))
    else $error("ready");
  a_byte_irq: assert property ($rose(byte_request) |=> byte_irq) else $error("byte");
  a_irq_hold: assert property (byte_irq && !irq_ack |=> byte_irq) else $error("hold");
  a_tc_pulse: assert property (sector_end_count |-> s_tc_done) else $error("tc");
  a_wr_early: assert property (ctrl_write.data && ctrl_write.early && !ctrl_write.late
    |=> write_data_out) else $error("precomp");
endmodule
bind fdg_glue fdg_glue_sva #(.drives(drives)) i_sva (.clk, .sys_rst, .unit_select_bit0,
  .unit_select_bit1, .head_load_req, .byte_request, .irq_ack, .drive_ready, .ctrl_write,
  .ctrl_ready, .byte_irq, .sector_irq, .sector_end_count, .drive_select_lines,
  .head_load_lines, .sep_count, .write_data_out);
`default_nettype wire

// ===== testbench/fdg_drive_model.sv
// drive side model: ready levels and read pulses of the selected drive.
// assumes one-hot selects; ready levels come from the bench.
`timescale 1ns/100ps
`default_nettype none
module fdg_drive_model
(
  // clock and selection
  input wire logic clk,
  input wire logic [3:0] drive_select_lines,
  input wire logic [3:0] ready_set,
  // drive lines
  output logic [3:0] drive_ready,
  output logic drive_read_pulses = 1'b0
);
  int cnt = 0;
  // pulse spacing off the reference grid so phase errors appear
  always @(posedge clk)
  begin
    drive_ready <= ready_set;
    cnt <= (cnt >= 66) ? 0 : cnt + 1;
    // no drive selected: line floats, shown as a toggling pattern
    drive_read_pulses <= (drive_select_lines == 4'h0) ? ~drive_read_pulses : (cnt == 0);
  end
endmodule
`default_nettype wire

// ===== testbench/fdg_glue_tb.sv
// testbench: decode loop, sector counting, separator monitor.
// assumes the drive model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module fdg_glue_tb import fdg_pkg::*;;
  logic clk = 1'b0, sys_rst = 1'b1, mfm_select = 1'b0, correction_disable = 1'b1;
  logic head_load_req = 1'b0, byte_request = 1'b0, sector_load = 1'b0, irq_ack = 1'b0;
  logic [1:0] unit = 2'h0;
  logic [3:0] switches = 4'h0, ready_set = 4'h0, drive_ready, drive_select_lines;
  logic [3:0] head_load_lines, sep_count, p_cnt = 4'h0;
  logic [15:0] sector_bytes = 16'h0000;
  fdg_cmd_s ctrl_cmd = '0, drive_cmd;
  fdg_wr_s ctrl_write = '0;
  logic drive_read_pulses, ctrl_ready, byte_irq, sector_irq, sector_end_count;
  logic write_data_out, read_data_window, p_dis = 1'b1, p_win = 1'b0;
  logic ctrl_clock, p_ck = 1'b0;
  integer errors = 0, n_compared = 0, seed = 20630, n_tc = 0, n_win = 0, i;
  integer n_ck = 0, n_wr = 0, exp_ck;
  int tab[16] = '{1, 1, 2, 3, 3, 4, 5, 6, 11, 12, 13, 14, 15, 15, 0, 1};
  initial forever #12.5 clk = ~clk;
  fdg_glue i_dut (.clk, .sys_rst, .clk_en(1'b1), .clock_divide_switches(switches),
    .mfm_select, .correction_disable, .unit_select_bit0(unit[0]), .unit_select_bit1(unit[1]),
    .head_load_req, .byte_request, .ctrl_cmd, .ctrl_write, .sector_load, .sector_bytes,
    .irq_ack, .drive_ready, .drive_read_pulses, .ctrl_clock, .ctrl_ready, .byte_irq,
    .sector_irq, .sector_end_count, .drive_select_lines, .head_load_lines, .drive_cmd,
    .write_data_out, .write_clock(), .density_reference_clock(), .read_data_window, .sep_count);
  fdg_drive_model i_drv (.clk, .drive_select_lines, .ready_set, .drive_ready, .drive_read_pulses);
  task automatic chk(input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("compared=%0d errors=%0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // monitor: each count change is one step or a table jump; sampled away from the edge
  always @(negedge clk)
  begin
    if (!sys_rst && ctrl_clock === 1'b1 && p_ck === 1'b0)
      n_ck++;
    if (!sys_rst && write_data_out === 1'b1)
      n_wr++;
    p_ck = ctrl_clock;
    if (!sys_rst && sep_count !== p_cnt)
      chk(sep_count == 4'(p_cnt + 1) || (!p_dis && sep_count == 4'(tab[p_cnt])), 1);
    if (read_data_window !== p_win)
      n_win++;
    if (sector_end_count === 1'b1)
      n_tc++;
    p_cnt = sep_count;
    p_dis = correction_disable;
    p_win = read_data_window;
  end
  // watchdog: the run needs about 5000 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test;
  end
  initial
  begin
    repeat (12) @(posedge clk);
    #1 chk({drive_select_lines, head_load_lines, sep_count}, 0);
    @(posedge clk);
    sys_rst <= 1'b0;
    // random units, ready levels, commands, write pulses
    for (i = 0; i < 40; i++)
    begin
      @(posedge clk);
      unit <= 2'($random(seed));
      ready_set <= 4'($random(seed));
      switches <= 4'($random(seed));
      head_load_req <= 1'($random(seed));
      ctrl_cmd <= 5'($random(seed));
      ctrl_write <= {1'b1, i[0], ~i[0]};
      @(posedge clk);
      ctrl_write <= '0;
      repeat (2) @(posedge clk);
      #1 chk(drive_select_lines, 4'h1 << unit);
      chk(head_load_lines, head_load_req ? 4'h1 << unit : 4'h0);
      chk(ctrl_ready, ready_set[unit]);
      chk(drive_cmd, ctrl_cmd);
    end
    // three-byte sector, each byte acknowledged, then one refused edge
    @(posedge clk);
    sector_bytes <= 16'h0003;
    sector_load <= 1'b1;
    @(posedge clk);
    sector_load <= 1'b0;
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk);
      byte_request <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk(sector_irq, i == 2);
      if (i < 3)
        chk(byte_irq, 1);
      @(posedge clk);
      irq_ack <= 1'b1;
      byte_request <= 1'b0;
      @(posedge clk);
      irq_ack <= 1'b0;
      #1 chk(byte_irq, 0);
    end
    chk(n_tc, 1);
    chk(n_wr, 40);
    // separator: plain count, then corrected in double density
    exp_ck = 4800 / (switches[unit] ? 4 : 2);
    n_ck = 0;
    repeat (800) @(posedge clk);
    correction_disable <= 1'b0;
    mfm_select <= 1'b1;
    repeat (4000) @(posedge clk);
    chk(n_win > 4, 1);
    chk(n_ck >= exp_ck - 1 && n_ck <= exp_ck + 1, 1);
    finish_test;
  end
endmodule
`default_nettype wire
